// File: timer_pkg.sv
// Constants for the cascaded 16-bit event/PWM timer
`default_nettype none
package timer_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_LOW_CTL  = 5'h00;
    localparam logic [4:0] OFS_HIGH_CTL = 5'h04;
    localparam logic [4:0] OFS_CMP_LO   = 5'h08;
    localparam logic [4:0] OFS_CMP_HI   = 5'h0C;
    localparam logic [4:0] OFS_PW_LO    = 5'h10;
    localparam logic [4:0] OFS_PW_HI    = 5'h14;
    localparam logic [4:0] OFS_COUNT    = 5'h18;
    // Low unit control fields
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    localparam int DIVSEL_BIT = 3;
    // High unit control fields
    localparam int MODE_BIT = 0;
    localparam int RUN_BIT  = 3;
    localparam int INIT_BIT = 7;
    // Reset values and counter constants
    localparam logic [7:0]  CTL_RST   = 8'h00;
    localparam logic [15:0] CMP_RST   = 16'hFFFF;
    localparam logic [15:0] PW_RST    = 16'h0000;
    localparam logic [15:0] CNT_TOP   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    // Source clock select codes
    localparam logic [2:0] SRC_SLOW  = 3'h0;
    localparam logic [2:0] SRC_DIV7  = 3'h1;
    localparam logic [2:0] SRC_DIV5  = 3'h2;
    localparam logic [2:0] SRC_DIV3  = 3'h3;
    localparam logic [2:0] SRC_FS    = 3'h4;
    localparam logic [2:0] SRC_DIV1  = 3'h5;
    localparam logic [2:0] SRC_FC    = 3'h6;
    localparam logic [2:0] SRC_EXT   = 3'h7;
    // Prescaler taps
    localparam int PRE_W = 11;
    localparam logic [10:0] PRE_11 = 11'h7FF;
    localparam logic [10:0] PRE_7  = 11'h07F;
    localparam logic [10:0] PRE_5  = 11'h01F;
    localparam logic [10:0] PRE_3  = 11'h007;
    localparam logic [10:0] PRE_1  = 11'h001;
    localparam logic [2:0]  FSDIV_TOP = 3'h7;
endpackage
`default_nettype wire

// File: cascaded_16bit_event_pwm_timer.sv
// Cascaded 16-bit event counter / PWM timer with Avalon-MM register slave
//
// Overview of operation
// - Low and high units form one 16-bit counter counting event-pin falling edges.
// - Event mode, running: count reaching compare raises period request and clears.
// - After a match the counter continues from zero on later falling edges.
// - Compare register is unbuffered; writes apply at once, avoid while running.
// - PWM mode counts a selected internal clock or the event-pin clock.
// - PWM mode: count equal to pulse width inverts output flip-flop, no clear.
// - PWM overflow inverts flip-flop again, clears counter, raises period request.
// - Output flip-flop loads from initial-value bit; reset clears it to zero.
// - PWM pin is the inverse of the output flip-flop.
// - Pulse width written while running is buffered, loaded at period request.
// - Pulse width written while stopped becomes active immediately.
// - Reading pulse width returns the active value, old until next request.
// - Stopping holds the pin; initial bit changed only in a later write.
// - Clearing run bit stops; then clearing initial bit drives PWM pin high.
`timescale 1ns/1ns
`default_nettype none
module cascaded_16bit_event_pwm_timer
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Pins
    input  wire logic        event_in_i,
    input  wire logic        low_freq_clk_i,
    output logic             pwm_out_n_o,
    output logic             period_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only feeds edge detection
    logic ev_meta_r, ev_sync_r, ev_prev_r;
    logic fs_meta_r, fs_sync_r, fs_prev_r;
    logic ev_fall, fs_tick;

    // Two-flop sync; event pulses must stay one cycle wide to be seen
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            ev_meta_r <= 1'b1;
            ev_sync_r <= 1'b1;
            ev_prev_r <= 1'b1;
            fs_meta_r <= 1'b0;
            fs_sync_r <= 1'b0;
            fs_prev_r <= 1'b0;
        end
        else
        begin
            ev_meta_r <= event_in_i;
            ev_sync_r <= ev_meta_r;
            ev_prev_r <= ev_sync_r;
            fs_meta_r <= low_freq_clk_i;
            fs_sync_r <= fs_meta_r;
            fs_prev_r <= fs_sync_r;
        end
    end

    assign ev_fall = ev_prev_r & ~ev_sync_r;
    assign fs_tick = fs_sync_r & ~fs_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler on the fast clock and divider on the slow clock
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [2:0]       fsdiv_r, fsdiv_nxt;

    always_comb
    begin
        pre_nxt   = pre_r + 11'h001;
        fsdiv_nxt = fs_tick ? fsdiv_r + 3'h1 : fsdiv_r;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            pre_r   <= '0;
            fsdiv_r <= '0;
        end
        else
        begin
            pre_r   <= pre_nxt;
            fsdiv_r <= fsdiv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state and timer core
    logic [7:0]  lowctl_r, lowctl_nxt;
    logic [7:0]  highctl_r, highctl_nxt;
    logic [15:0] cmp_r, cmp_nxt;
    logic [7:0]  pwlo_r, pwlo_nxt;
    logic [7:0]  pwhi_r, pwhi_nxt;
    logic [15:0] act_r, act_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        ff_r, ff_nxt;
    logic        pin_r, pin_nxt;
    logic        irq_r, irq_nxt;
    logic        wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wr_fire, run, pwm_mode, src_tick, tick;
    logic [2:0]  sel;
    logic [15:0] cnt_inc;

    assign run      = highctl_r[RUN_BIT];
    assign pwm_mode = highctl_r[MODE_BIT];
    assign sel      = lowctl_r[SEL_MSB:SEL_LSB];
    assign cnt_inc  = cnt_r + CNT_ONE;
    // Writes land on the edge where waitrequest is seen low
    assign wr_fire  = avs_write_i & ~wait_r & avs_byteenable_i[0];

    // Source clock selection for PWM mode
    always_comb
    begin
        case (sel)
            SRC_SLOW: src_tick = lowctl_r[DIVSEL_BIT] ? (fs_tick && fsdiv_r == FSDIV_TOP)
                                                      : (pre_r == PRE_11);
            SRC_DIV7: src_tick = (pre_r[6:0] == PRE_7[6:0]);
            SRC_DIV5: src_tick = (pre_r[4:0] == PRE_5[4:0]);
            SRC_DIV3: src_tick = (pre_r[2:0] == PRE_3[2:0]);
            SRC_FS:   src_tick = fs_tick;
            SRC_DIV1: src_tick = (pre_r[0] == PRE_1[0]);
            SRC_FC:   src_tick = 1'b1;
            default:  src_tick = ev_fall;
        endcase
        // Event counter mode always follows the event pin
        tick = pwm_mode ? src_tick : ev_fall;
    end

    // Register writes, counting and output flip-flop
    always_comb
    begin
        lowctl_nxt  = lowctl_r;
        highctl_nxt = highctl_r;
        cmp_nxt     = cmp_r;
        pwlo_nxt    = pwlo_r;
        pwhi_nxt    = pwhi_r;
        act_nxt     = act_r;
        cnt_nxt     = cnt_r;
        ff_nxt      = ff_r;
        irq_nxt     = 1'b0;
        if (wr_fire)
        begin
            case (avs_address_i)
                OFS_LOW_CTL:  lowctl_nxt = avs_writedata_i[7:0];
                OFS_HIGH_CTL:
                begin
                    highctl_nxt = avs_writedata_i[7:0];
                    // A write that stops the timer must not move the pin
                    if (!run)
                        ff_nxt = avs_writedata_i[INIT_BIT];
                end
                OFS_CMP_LO:   cmp_nxt[7:0]  = avs_writedata_i[7:0];
                OFS_CMP_HI:   cmp_nxt[15:8] = avs_writedata_i[7:0];
                OFS_PW_LO:    pwlo_nxt = avs_writedata_i[7:0];
                OFS_PW_HI:
                begin
                    pwhi_nxt = avs_writedata_i[7:0];
                    if (!run)
                        act_nxt = {avs_writedata_i[7:0], pwlo_r};
                end
                default: ;
            endcase
        end
        // Stopped counter sits at zero so a restart begins a full period
        if (!run)
            cnt_nxt = CNT_ZERO;
        else if (tick && !pwm_mode)
        begin
            if (cnt_inc == cmp_r)
            begin
                cnt_nxt = CNT_ZERO;
                irq_nxt = 1'b1;
            end
            else
                cnt_nxt = cnt_inc;
        end
        else if (tick)
        begin
            if (cnt_r == CNT_TOP)
            begin
                // Reload can race a software write; the buffer value wins as it stood
                cnt_nxt = CNT_ZERO;
                ff_nxt  = ~ff_r;
                irq_nxt = 1'b1;
                act_nxt = {pwhi_r, pwlo_r};
            end
            else
            begin
                cnt_nxt = cnt_inc;
                if (cnt_inc == act_r)
                    ff_nxt = ~ff_r;
            end
        end
        pin_nxt = ~ff_nxt;
    end

    // Avalon-MM: one wait cycle, read data prepared while waitrequest is high
    always_comb
    begin
        wait_nxt  = 1'b1;
        rdata_nxt = rdata_r;
        if ((avs_read_i || avs_write_i) && wait_r)
        begin
            wait_nxt  = 1'b0;
            rdata_nxt = 32'h0000_0000;
            case (avs_address_i)
                OFS_LOW_CTL:  rdata_nxt[7:0]  = lowctl_r;
                OFS_HIGH_CTL: rdata_nxt[7:0]  = highctl_r;
                OFS_CMP_LO:   rdata_nxt[7:0]  = cmp_r[7:0];
                OFS_CMP_HI:   rdata_nxt[7:0]  = cmp_r[15:8];
                OFS_PW_LO:    rdata_nxt[7:0]  = act_r[7:0];
                OFS_PW_HI:    rdata_nxt[7:0]  = act_r[15:8];
                OFS_COUNT:    rdata_nxt[15:0] = cnt_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            lowctl_r  <= CTL_RST;
            highctl_r <= CTL_RST;
            cmp_r     <= CMP_RST;
            pwlo_r    <= PW_RST[7:0];
            pwhi_r    <= PW_RST[15:8];
            act_r     <= PW_RST;
            cnt_r     <= CNT_ZERO;
            ff_r      <= 1'b0;
            pin_r     <= 1'b1;
            irq_r     <= 1'b0;
            wait_r    <= 1'b1;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            lowctl_r  <= lowctl_nxt;
            highctl_r <= highctl_nxt;
            cmp_r     <= cmp_nxt;
            pwlo_r    <= pwlo_nxt;
            pwhi_r    <= pwhi_nxt;
            act_r     <= act_nxt;
            cnt_r     <= cnt_nxt;
            ff_r      <= ff_nxt;
            pin_r     <= pin_nxt;
            irq_r     <= irq_nxt;
            wait_r    <= wait_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign pwm_out_n_o       = pin_r;
    assign period_irq_o      = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    pin_inverse_a: assert property (pwm_out_n_o == !ff_r)
        else $error("pwm pin not inverse of flip-flop");
    ev_count_a: assert property (run && !pwm_mode && ev_fall && cnt_inc != cmp_r
        |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("event edge not counted");
    ev_match_a: assert property (run && !pwm_mode && ev_fall && cnt_inc == cmp_r
        |=> period_irq_o && cnt_r == CNT_ZERO)
        else $error("event match did not clear and request");
    ev_restart_a: assert property (run && !pwm_mode && ev_fall && cnt_r == CNT_ZERO && cmp_r != CNT_ONE
        |=> cnt_r == CNT_ONE)
        else $error("counter did not restart from zero");
    cmp_direct_a: assert property (wr_fire && avs_address_i == OFS_CMP_HI
        |=> cmp_r[15:8] == $past(avs_writedata_i[7:0]))
        else $error("compare write not immediate");
    pwm_match_a: assert property (run && pwm_mode && tick && cnt_r != CNT_TOP && cnt_inc == act_r
        |=> ff_r != $past(ff_r) && cnt_r != CNT_ZERO)
        else $error("pulse width match wrong");
    pwm_ovf_a: assert property (run && pwm_mode && tick && cnt_r == CNT_TOP
        |=> period_irq_o && cnt_r == CNT_ZERO && ff_r != $past(ff_r))
        else $error("overflow handling wrong");
    pw_reload_a: assert property (run && pwm_mode && tick && cnt_r == CNT_TOP
        |=> act_r == {$past(pwhi_r), $past(pwlo_r)})
        else $error("pulse width not reloaded at period");
    pw_stopped_a: assert property (!run && wr_fire && avs_address_i == OFS_PW_HI
        |=> act_r == {$past(avs_writedata_i[7:0]), $past(pwlo_r)})
        else $error("stopped pulse width not immediate");
    pw_read_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_PW_LO
        |-> avs_readdata_o[7:0] == $past(act_r[7:0]))
        else $error("pulse width readback not active value");
    init_load_a: assert property (!run && wr_fire && avs_address_i == OFS_HIGH_CTL
        |=> ff_r == $past(avs_writedata_i[INIT_BIT]))
        else $error("initial value not loaded");
    stop_hold_a: assert property (run && wr_fire && avs_address_i == OFS_HIGH_CTL
        && !avs_writedata_i[RUN_BIT] |=> !run ##1 $stable(pwm_out_n_o))
        else $error("pin moved after stop");
    fc_source_a: assert property (run && pwm_mode && sel == SRC_FC && !wr_fire && cnt_r < 16'hFFF0
        |=> (cnt_r == $past(cnt_r) + CNT_ONE) [*2])
        else $error("fast clock source not counting each cycle");

    ev_irq_c: cover property (run && !pwm_mode && period_irq_o);
    pwm_ovf_c: cover property (run && pwm_mode && period_irq_o);
    pw_write_run_c: cover property (run && wr_fire && avs_address_i == OFS_PW_HI);
    stop_c: cover property (run ##1 !run);

endmodule
`default_nettype wire

// File: event_source.sv
// Event pulse source model that drives the timer's event pin
`timescale 1ns/1ns
`default_nettype none
module event_source
#(
    parameter int HOLD = 3
)
(
    // Clock
    input  wire logic       clk_i,
    // Request from the bench
    input  wire logic       start_i,
    input  wire logic [7:0] count_i,
    // Pin side
    output logic            event_o,
    output logic            busy_o
);
    logic [7:0] left_r = 8'h00;
    logic [3:0] ph_r   = 4'h0;
    ////////////////////////////////////////////////////////////////
    // Each level lasts HOLD cycles, so no edge outruns the input sync
    always_ff @(posedge clk_i)
    begin
        if (start_i && left_r == 8'h00)
        begin
            left_r <= count_i;
            ph_r   <= 4'h0;
        end
        else if (left_r != 8'h00)
        begin
            ph_r <= (ph_r == 4'(2 * HOLD - 1)) ? 4'h0 : ph_r + 4'h1;
            if (ph_r == 4'(2 * HOLD - 1))
                left_r <= left_r - 8'h01;
        end
    end
    // Pin idles high; a pulse is a low phase followed by a high phase
    assign event_o = !(left_r != 8'h00 && ph_r < 4'(HOLD));
    assign busy_o  = (left_r != 8'h00);
endmodule
`default_nettype wire

// File: test_cascaded_16bit_event_pwm_timer.sv
// Self-checking bench for the cascaded event/PWM timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_cascaded_16bit_event_pwm_timer;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        es_go = 1'b0;
    logic        evt, pwm_n, irq, wreq, es_busy;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [3:0]  ben = 4'hF;
    logic [3:0]  fsdiv = 4'h0;
    logic [7:0]  es_n = 8'h00;
    logic [15:0] po, pn;
    int          checks = 0, mismatches = 0, irqs = 0, lowcnt = 0, cyc = 0;
    int          c, mcnt, mirq, l0, i0, t0, x;
    int          ctl[8] = '{0, 8, 1, 2, 3, 4, 5, 6};
    int          dv[8] = '{2048, 128, 128, 32, 8, 16, 2, 1};
    ////////////////////////////////////////////////////////////////
    // Clock, slow clock (period 16) and event watchers
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        fsdiv  <= fsdiv + 4'h1;
        cyc    <= cyc + 1;
        irqs   <= irqs + int'(irq === 1'b1);
        lowcnt <= lowcnt + int'(pwm_n === 1'b0);
    end
    cascaded_16bit_event_pwm_timer cascaded_16bit_event_pwm_timer_i (.ref_clk_i(clk), .resetn_i(rstn),
        .avs_address_i(adr), .avs_read_i(re), .avs_write_i(we), .avs_writedata_i(wd),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .event_in_i(evt), .low_freq_clk_i(fsdiv[3]), .pwm_out_n_o(pwm_n), .period_irq_o(irq));
    event_source event_source_i (.clk_i(clk), .start_i(es_go), .count_i(es_n), .event_o(evt),
        .busy_o(es_busy));
    ////////////////////////////////////////////////////////////////
    // Bus cycles hold the request until waitrequest is seen low
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
        @(posedge clk) begin adr <= a; wd <= {24'h0, d}; ben <= be; we <= 1'b1; end
        do @(posedge clk); while (wreq !== 1'b0);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk) begin adr <= a; re <= 1'b1; end
        do @(posedge clk); while (wreq !== 1'b0);
        v = rdat;
        re <= 1'b0;
    endtask
    // Send n falling edges and step the reference count the same way
    task automatic pulses(input int n);
        @(posedge clk) begin es_n <= 8'(n); es_go <= 1'b1; end
        @(posedge clk) es_go <= 1'b0;
        @(posedge clk);
        while (es_busy) @(posedge clk);
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            mcnt++;
            if (mcnt == c) begin mcnt = 0; mirq++; end
        end
        rd(5'h18);
        `CHK(v, 32'(mcnt))
        `CHK(irqs, mirq)
    endtask
    task automatic test_done;
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog sized a little past the longest PWM period plus setup
    initial
    begin
        repeat (95000) @(posedge clk);
        mismatches++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(80));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK(pwm_n, 1'b1)
        for (int i = 0; i < 8; i++)
        begin
            rd(5'(4 * i));
            `CHK(v, (i == 2 || i == 3) ? 32'hFF : 32'h0)
        end
        wr(5'h08, 8'h12, 4'hE);
        rd(5'h08);
        `CHK(v, 32'hFF)
        // Event counting with a small random compare, then a live change
        c = $urandom_range(6, 2);
        mcnt = 0;
        mirq = 0;
        wr(5'h08, 8'(c));
        wr(5'h0C, 8'h00);
        wr(5'h00, 8'h07);
        wr(5'h04, 8'h08);
        pulses(c - 1);
        pulses(1);
        pulses(2);
        c = mcnt + 1;
        wr(5'h08, 8'(c));
        pulses(1);
        wr(5'h04, 8'h00);
        // Source select codes 0 to 6 each advance the count at their own rate
        for (int k = 0; k < 8; k++)
        begin
            wr(5'h00, 8'(ctl[k]));
            wr(5'h04, 8'h09);
            repeat (2048) @(posedge clk);
            rd(5'h18);
            wr(5'h04, 8'h01);
            x = int'(v[15:0]);
            `CHK(x >= 2048 / dv[k] - 2 && x <= 2048 / dv[k] + 3, 1'b1)
        end
        // Event pin as PWM source: no period request before overflow
        mcnt = 0;
        c = 0;
        wr(5'h00, 8'h07);
        wr(5'h04, 8'h09);
        pulses(5);
        wr(5'h04, 8'h01);
        // PWM from the fast clock with a random width, reloaded mid-run
        po = 16'($urandom_range(16'hFF00, 16'h8000));
        pn = 16'($urandom_range(255, 16));
        wr(5'h00, 8'h06);
        wr(5'h04, 8'h01);
        wr(5'h10, po[7:0]);
        wr(5'h14, po[15:8]);
        rd(5'h14);
        `CHK(v[7:0], po[15:8])
        l0 = lowcnt;
        i0 = irqs;
        wr(5'h04, 8'h09);
        wr(5'h10, pn[7:0]);
        wr(5'h14, pn[15:8]);
        rd(5'h10);
        `CHK(v[7:0], po[7:0])
        while (irqs == i0) @(posedge clk);
        t0 = cyc;
        `CHK(lowcnt - l0, 65536 - int'(po))
        rd(5'h14);
        `CHK(v[7:0], pn[15:8])
        while (pwm_n !== 1'b0) @(posedge clk);
        x = cyc - t0;
        `CHK(x >= int'(pn) - 3 && x <= int'(pn) + 3, 1'b1)
        // Stop holds the level; only a later write reloads the flip-flop
        wr(5'h04, 8'h01);
        repeat (5) @(posedge clk);
        `CHK(pwm_n, 1'b0)
        wr(5'h04, 8'h01);
        @(posedge clk);
        `CHK(pwm_n, 1'b1)
        wr(5'h04, 8'h81);
        @(posedge clk);
        `CHK(pwm_n, 1'b0)
        test_done;
    end
endmodule
`default_nettype wire
